/* dpt_params.svh */
`ifndef DPT_PARAMS_SVH
`define DPT_PARAMS_SVH

// Register byte offsets on the APB bus
`define DPT_ADDR_W        8
`define DPT_MC0_OFF       8'h00
`define DPT_CS0_OFF       8'h04
`define DPT_CV0_OFF       8'h08
`define DPT_CC0_OFF       8'h0C
`define DPT_MC1_OFF       8'h10
`define DPT_CS1_OFF       8'h14
`define DPT_CV1_OFF       8'h18
`define DPT_CC1_OFF       8'h1C

// Mode control field positions
`define DPT_RUN_BIT       7
`define DPT_PWM_BIT       6
`define DPT_ZERO_BIT      5
`define DPT_CASC_BIT      4
`define DPT_PSET_HI_BIT   3
`define DPT_PSET_LO_BIT   2
`define DPT_TOG_BIT       1
`define DPT_OE_BIT        0
`define DPT_PSET_MASK     8'h0C

// Reset values and counter maximum
`define DPT_MC_RESET      8'h04
`define DPT_CS_RESET      3'h0
`define DPT_CNT_RESET     8'h00
`define DPT_CNT_MAX       8'hFF

// Clock select codes and prescaler masks (divide by mask + 1)
`define DPT_CS_FALL       3'h0
`define DPT_CS_RISE       3'h1
`define DPT_PRE_W         9
`define DPT_MASK_DIV4     9'h003
`define DPT_MASK_DIV8     9'h007
`define DPT_MASK_DIV16    9'h00F
`define DPT_MASK_DIV32    9'h01F
`define DPT_MASK_DIV128   9'h07F
`define DPT_MASK_DIV512   9'h1FF

`endif

/* dpt_pkg.sv */
`include "dpt_params.svh"

package dpt_pkg;

  typedef logic [7:0] dpt_byte_t;
  typedef logic [`DPT_PRE_W-1:0] dpt_pre_t;

  typedef enum logic [3:0] {
    DPT_REG_MC0,
    DPT_REG_CS0,
    DPT_REG_CV0,
    DPT_REG_CC0,
    DPT_REG_MC1,
    DPT_REG_CS1,
    DPT_REG_CV1,
    DPT_REG_CC1,
    DPT_REG_NONE
  } dpt_reg_e;

  function automatic dpt_pre_t dpt_div_mask(input logic [2:0] sel);
    case (sel)
      3'h2:    dpt_div_mask = `DPT_MASK_DIV4;
      3'h3:    dpt_div_mask = `DPT_MASK_DIV8;
      3'h4:    dpt_div_mask = `DPT_MASK_DIV16;
      3'h5:    dpt_div_mask = `DPT_MASK_DIV32;
      3'h6:    dpt_div_mask = `DPT_MASK_DIV128;
      default: dpt_div_mask = `DPT_MASK_DIV512;
    endcase
  endfunction : dpt_div_mask

endpackage : dpt_pkg

/* dpt_tick_if.sv */
`timescale 1ns/1ps

interface dpt_tick_if;
  logic       run;
  logic       hold;
  logic [2:0] sel;
  logic       pin;
  logic       tick;

  modport gen
  (
    input  run,
    input  hold,
    input  sel,
    input  pin,
    output tick
  );

  modport user
  (
    output run,
    output hold,
    output sel,
    output pin,
    input  tick
  );
endinterface : dpt_tick_if

/* dpt_tick_gen.sv */
`timescale 1ns/1ps
`include "dpt_params.svh"

module dpt_tick_gen
  import dpt_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  dpt_tick_if.gen   tk
);

  dpt_pre_t prescale;
  logic     pin_prev;
  logic     edge_pend;
  logic     edge_seen;
  logic     pin_mode;

  assign pin_mode = (tk.sel == `DPT_CS_FALL) || (tk.sel == `DPT_CS_RISE);

  always_comb
  begin
    case (tk.sel)
      `DPT_CS_FALL: edge_seen = pin_prev & ~tk.pin;
      `DPT_CS_RISE: edge_seen = ~pin_prev & tk.pin;
      default:      edge_seen = 1'b0;
    endcase
  end

  // Prescaler cleared while stopped, so start phase is aligned
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      prescale <= '0;
    else if (!tk.run)
      prescale <= '0;
    else if (!tk.hold)
      prescale <= prescale + 1'b1;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      pin_prev <= 1'b0;
    else
      pin_prev <= tk.pin;
  end

  // An edge during a counter read is kept, not lost
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      edge_pend <= 1'b0;
    else if (!tk.run)
      edge_pend <= 1'b0;
    else if (tk.hold && edge_seen)
      edge_pend <= 1'b1;
    else if (!tk.hold)
      edge_pend <= 1'b0;
  end

  always_comb
  begin
    if (!tk.run || tk.hold)
      tk.tick = 1'b0;
    else if (pin_mode)
      tk.tick = edge_seen | edge_pend;
    else
      tk.tick = (prescale & dpt_div_mask(tk.sel)) == dpt_div_mask(tk.sel);
  end

endmodule : dpt_tick_gen

/* dpt_top.sv */
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "dpt_params.svh"

module dpt_top
  import dpt_pkg::*;
(
  input  wire  logic        clk_in,
  input  wire  logic        rst_in,
  input  wire  logic        psel_in,
  input  wire  logic        penable_in,
  input  wire  logic        pwrite_in,
  input  wire  logic [7:0]  paddr_in,
  input  wire  logic [31:0] pwdata_in,
  output logic       [31:0] prdata_out,
  output logic              pready_out,
  output logic              pslverr_out,
  input  wire  logic [1:0]  timer_pin_in,
  output logic       [1:0]  timer_pin_out,
  output logic       [1:0]  timer_pin_oe_n_out,
  output logic       [1:0]  match_interrupt_out
);

  function automatic dpt_reg_e dpt_decode(input logic [7:0] addr);
    case (addr)
      `DPT_MC0_OFF: dpt_decode = DPT_REG_MC0;
      `DPT_CS0_OFF: dpt_decode = DPT_REG_CS0;
      `DPT_CV0_OFF: dpt_decode = DPT_REG_CV0;
      `DPT_CC0_OFF: dpt_decode = DPT_REG_CC0;
      `DPT_MC1_OFF: dpt_decode = DPT_REG_MC1;
      `DPT_CS1_OFF: dpt_decode = DPT_REG_CS1;
      `DPT_CV1_OFF: dpt_decode = DPT_REG_CV1;
      `DPT_CC1_OFF: dpt_decode = DPT_REG_CC1;
      default:      dpt_decode = DPT_REG_NONE;
    endcase
  endfunction : dpt_decode

  dpt_byte_t   mode_control    [2];
  logic [2:0]  clock_select    [2];
  dpt_byte_t   compare_value   [2];
  dpt_byte_t   channel_counter [2];
  logic [1:0]  pwm_active;

  dpt_reg_e    sel_reg;
  logic        wr_en;
  logic        rd_req;
  logic [31:0] rd_mux;

  logic [1:0]  run;
  logic [1:0]  pwm;
  logic        cascade;
  logic [1:0]  tick;
  logic [1:0]  match;
  logic [1:0]  event_hit;
  logic [1:0]  preset_hi_wr;
  logic [1:0]  preset_lo_wr;
  logic [15:0] cnt16;
  logic [15:0] cmp16;
  logic [15:0] next_cnt16;
  logic        match16;
  logic        second_half_hit;
  dpt_byte_t   next_cnt [2];

  dpt_tick_if  tk0 ();
  dpt_tick_if  tk1 ();

  assign sel_reg = dpt_decode(paddr_in);
  assign wr_en   = psel_in & penable_in & pready_out & pwrite_in;
  assign rd_req  = psel_in & ~pwrite_in;

  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      run[i]      = mode_control[i][`DPT_RUN_BIT];
      pwm[i]      = mode_control[i][`DPT_PWM_BIT];
      match[i]    = channel_counter[i] == compare_value[i];
      next_cnt[i] = channel_counter[i] + 8'h01;
    end
    cascade = mode_control[1][`DPT_CASC_BIT];
  end

  // Count clocks; in cascade the second prescaler idles
  assign tk0.run  = run[0];
  assign tk0.sel  = clock_select[0];
  assign tk0.pin  = timer_pin_in[0];
  assign tk0.hold = (rd_req && sel_reg == DPT_REG_CC0)
                    || (cascade && rd_req && sel_reg == DPT_REG_CC1);
  assign tk1.run  = run[1] & ~cascade;
  assign tk1.sel  = clock_select[1];
  assign tk1.pin  = timer_pin_in[1];
  assign tk1.hold = rd_req && sel_reg == DPT_REG_CC1;
  assign tick[0]  = tk0.tick;
  assign tick[1]  = tk1.tick;

  dpt_tick_gen u_tick0
  (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .tk     (tk0)
  );

  dpt_tick_gen u_tick1
  (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .tk     (tk1)
  );

  // Cascaded view of both halves
  assign cnt16           = {channel_counter[1], channel_counter[0]};
  assign cmp16           = {compare_value[1], compare_value[0]};
  assign next_cnt16      = cnt16 + 16'h0001;
  assign match16         = cnt16 == cmp16;
  assign second_half_hit = (next_cnt16[15:8] == compare_value[1])
                           && (channel_counter[1] != compare_value[1]);

  always_comb
  begin
    if (cascade)
    begin
      event_hit[0] = run[0] & tick[0] & match16;
      event_hit[1] = run[0] & tick[0] & ~match16 & second_half_hit;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
        event_hit[i] = run[i] & tick[i] & ~pwm[i] & match[i];
    end
  end

  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      preset_hi_wr[i] = 1'b0;
      preset_lo_wr[i] = 1'b0;
    end
    if (wr_en && (sel_reg == DPT_REG_MC0 || sel_reg == DPT_REG_MC1))
    begin
      for (int i = 0; i < 2; i++)
      begin
        if ((sel_reg == DPT_REG_MC1) == (i == 1))
        begin
          preset_hi_wr[i] = pwdata_in[`DPT_PSET_HI_BIT] & ~pwdata_in[`DPT_PSET_LO_BIT];
          preset_lo_wr[i] = ~pwdata_in[`DPT_PSET_HI_BIT] & pwdata_in[`DPT_PSET_LO_BIT];
        end
      end
    end
  end

  // Software register writes
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < 2; i++)
      begin
        mode_control[i]  <= `DPT_MC_RESET;
        clock_select[i]  <= `DPT_CS_RESET;
        compare_value[i] <= `DPT_CNT_RESET;
      end
    end
    else if (wr_en)
    begin
      case (sel_reg)
        DPT_REG_MC0:
        begin
          mode_control[0]                   <= pwdata_in[7:0];
          mode_control[0][`DPT_ZERO_BIT]    <= 1'b0;
          mode_control[0][`DPT_CASC_BIT]    <= 1'b0;
          mode_control[0][`DPT_PSET_HI_BIT] <= 1'b0;
          mode_control[0][`DPT_PSET_LO_BIT] <= 1'b0;
        end
        DPT_REG_MC1:
        begin
          mode_control[1]                   <= pwdata_in[7:0];
          mode_control[1][`DPT_ZERO_BIT]    <= 1'b0;
          mode_control[1][`DPT_PSET_HI_BIT] <= 1'b0;
          mode_control[1][`DPT_PSET_LO_BIT] <= 1'b0;
        end
        DPT_REG_CS0: clock_select[0]  <= pwdata_in[2:0];
        DPT_REG_CS1: clock_select[1]  <= pwdata_in[2:0];
        // Taken at once; a mid-count rewrite relies on software pacing
        DPT_REG_CV0: compare_value[0] <= pwdata_in[7:0];
        DPT_REG_CV1: compare_value[1] <= pwdata_in[7:0];
        default:
        begin
        end
      endcase
    end
  end

  // Counters; 8-bit wrap (16-bit wrap in cascade) covers a compare set below the count
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < 2; i++)
        channel_counter[i] <= `DPT_CNT_RESET;
    end
    else if (cascade)
    begin
      if (!run[0])
      begin
        channel_counter[0] <= `DPT_CNT_RESET;
        channel_counter[1] <= `DPT_CNT_RESET;
      end
      else if (tick[0])
      begin
        if (match16)
        begin
          channel_counter[0] <= `DPT_CNT_RESET;
          channel_counter[1] <= `DPT_CNT_RESET;
        end
        else
        begin
          channel_counter[0] <= next_cnt16[7:0];
          channel_counter[1] <= next_cnt16[15:8];
        end
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (!run[i])
          channel_counter[i] <= `DPT_CNT_RESET;
        else if (tick[i])
        begin
          if (!pwm[i] && match[i])
            channel_counter[i] <= `DPT_CNT_RESET;
          else
            channel_counter[i] <= next_cnt[i];
        end
      end
    end
  end

  // PWM active phase: overflow sets it, match clears it
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      pwm_active <= 2'b00;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (!run[i] || !pwm[i] || (i == 1 && cascade))
          pwm_active[i] <= 1'b0;
        else if (tick[i])
        begin
          if (next_cnt[i] == compare_value[i])
            pwm_active[i] <= 1'b0;
          else if (channel_counter[i] == `DPT_CNT_MAX)
            pwm_active[i] <= 1'b1;
        end
      end
    end
  end

  // Timer output level; preset write wins over a hardware event
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      timer_pin_out <= 2'b00;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (preset_hi_wr[i])
          timer_pin_out[i] <= 1'b1;
        else if (preset_lo_wr[i])
          timer_pin_out[i] <= 1'b0;
        else if (pwm[i] && !(i == 1 && cascade))
          timer_pin_out[i] <= pwm_active[i] ^ mode_control[i][`DPT_TOG_BIT];
        else if (event_hit[i] && mode_control[i][`DPT_TOG_BIT])
          timer_pin_out[i] <= ~timer_pin_out[i];
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      timer_pin_oe_n_out <= 2'b11;
    else
    begin
      for (int i = 0; i < 2; i++)
        timer_pin_oe_n_out[i] <= ~mode_control[i][`DPT_OE_BIT];
    end
  end

  // One-clock pulse, one edge after detection
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      match_interrupt_out <= 2'b00;
    else
      match_interrupt_out <= event_hit;
  end

  always_comb
  begin
    case (sel_reg)
      DPT_REG_MC0: rd_mux = {24'h000000, mode_control[0] & ~`DPT_PSET_MASK};
      DPT_REG_MC1: rd_mux = {24'h000000, mode_control[1] & ~`DPT_PSET_MASK};
      DPT_REG_CS0: rd_mux = {29'h0000000, clock_select[0]};
      DPT_REG_CS1: rd_mux = {29'h0000000, clock_select[1]};
      DPT_REG_CV0: rd_mux = {24'h000000, compare_value[0]};
      DPT_REG_CV1: rd_mux = {24'h000000, compare_value[1]};
      DPT_REG_CC0: rd_mux = {24'h000000, channel_counter[0]};
      DPT_REG_CC1: rd_mux = {24'h000000, channel_counter[1]};
      default:     rd_mux = 32'h00000000;
    endcase
  end

  // One wait state; count clock is held for the whole of a counter read
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h00000000;
    end
    else if (psel_in && penable_in && !pready_out)
    begin
      pready_out  <= 1'b1;
      pslverr_out <= sel_reg == DPT_REG_NONE;
      prdata_out  <= pwrite_in ? 32'h00000000 : rd_mux;
    end
    else
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

endmodule : dpt_top

/* dpt_evt_src.sv */
`timescale 1ns/1ps

module dpt_evt_src
(
  input  wire logic       clk_in,
  input  wire logic       go_in,
  input  wire logic       slow_in,
  input  wire logic [1:0] oe_n_in,
  input  wire logic [1:0] drv_in,
  output logic      [1:0] pin_out,
  output logic            busy_out
);
  logic [4:0] edges_left = 5'h00;
  logic [2:0] dwell      = 3'h0;
  logic       level      = 1'b0;

  // Eight whole pulses: sixteen edges, ends low
  always @(posedge clk_in)
    if (go_in)
    begin
      edges_left <= 5'h10;
      dwell <= 3'h0;
    end
    else if (edges_left != 5'h00)
    begin
      if (dwell == (slow_in ? 3'h5 : 3'h1))
      begin
        level <= ~level;
        edges_left <= edges_left - 5'h01;
        dwell <= 3'h0;
      end
      else
        dwell <= dwell + 3'h1;
    end

  assign busy_out = (edges_left != 5'h00);
  // Pull-down holds undriven pin 1 low; undriven pin 0 follows the event source; a driving timer wins
  assign pin_out = {oe_n_in[1] ? 1'b0 : drv_in[1], oe_n_in[0] ? level : drv_in[0]};
endmodule : dpt_evt_src

/* dpt_top_props.sv */
`timescale 1ns/1ps
`include "dpt_params.svh"

module dpt_top_props
  import dpt_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic [1:0]  timer_pin_out,
  input wire logic [1:0]  timer_pin_oe_n_out,
  input wire logic [1:0]  match_interrupt_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  logic       acc0;
  logic       wr0;
  dpt_byte_t  mc0;
  logic [2:0] quiet;

  assign acc0 = psel_in & penable_in & pready_out & (paddr_in == `DPT_MC0_OFF);
  assign wr0  = acc0 & pwrite_in;

  // Shadow of the mode so checks know what software asked for
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      mc0 <= `DPT_MC_RESET;
    else if (wr0)
      mc0 <= pwdata_in[7:0];

  // Outputs settle a few clocks after a mode write
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      quiet <= 3'h0;
    else if (wr0)
      quiet <= 3'h0;
    else if (quiet != 3'h7)
      quiet <= quiet + 3'h1;

  property p_irq0_pulse;
    match_interrupt_out[0] |=> !match_interrupt_out[0];
  endproperty
  a_irq0_pulse: assert property (p_irq0_pulse) else $error("irq 0 too long");

  property p_irq1_pulse;
    match_interrupt_out[1] |=> !match_interrupt_out[1];
  endproperty
  a_irq1_pulse: assert property (p_irq1_pulse) else $error("irq 1 too long");

  property p_oe;
    wr0 |-> ##2 timer_pin_oe_n_out[0] == !$past(pwdata_in[`DPT_OE_BIT], 2);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");

  property p_pset_hi;
    wr0 && pwdata_in[7:2] == 6'h02 |-> ##2 timer_pin_out[0];
  endproperty
  a_pset_hi: assert property (p_pset_hi) else $error("preset high lost");

  property p_pset_lo;
    wr0 && pwdata_in[7:2] == 6'h01 |-> ##2 !timer_pin_out[0];
  endproperty
  a_pset_lo: assert property (p_pset_lo) else $error("preset low lost");

  property p_rd_pset;
    acc0 && !pwrite_in |-> prdata_out[3:2] == 2'h0;
  endproperty
  a_rd_pset: assert property (p_rd_pset) else $error("preset bits read back");

  property p_stop;
    mc0[6] && !mc0[7] && mc0[0] && quiet == 3'h7 |-> timer_pin_out[0] == mc0[1];
  endproperty
  a_stop: assert property (p_stop) else $error("stopped output not inactive");

  property p_tog;
    !mc0[6] && mc0[1] && quiet == 3'h7
      |-> $changed(timer_pin_out[0]) == match_interrupt_out[0];
  endproperty
  a_tog: assert property (p_tog) else $error("toggle not tied to match");

  property p_pwm_quiet;
    mc0[6] && quiet == 3'h7 |-> !match_interrupt_out[0];
  endproperty
  a_pwm_quiet: assert property (p_pwm_quiet) else $error("irq in pwm mode");

  c_match: cover property (match_interrupt_out[0]);
  c_casc: cover property (match_interrupt_out[1]);
  c_pwm: cover property (mc0[6] && mc0[7] && timer_pin_out[0]);
endmodule : dpt_top_props

bind dpt_top dpt_top_props u_props (.*);

/* tb_dual_8bit_pwm_timer.sv */
`timescale 1ns/1ps
`include "dpt_params.svh"

module tb_dual_8bit_pwm_timer;
  typedef struct packed {logic [2:0] cs; logic [7:0] cv; logic [15:0] per;} dpt_row_s;

  logic        clk_in;
  logic        rst_in;
  logic        psel_in;
  logic        penable_in;
  logic        pwrite_in;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic [1:0]  timer_pin_in;
  logic [1:0]  timer_pin_out;
  logic [1:0]  timer_pin_oe_n_out;
  logic [1:0]  match_interrupt_out;
  logic        go;
  logic        slow;
  logic        busy;
  logic [31:0] r;
  logic        e;
  logic [31:0] r0;
  int          fail_count;
  int          checks;
  int          n0;
  int          n1;
  int          c;
  // Period in clocks is (compare + 1) times the divider
  dpt_row_s    rows [6] = '{'{3'h2, 8'h05, 16'h0018}, '{3'h3, 8'h00, 16'h0008},
                            '{3'h4, 8'h02, 16'h0030}, '{3'h5, 8'h01, 16'h0040},
                            '{3'h6, 8'h01, 16'h0100}, '{3'h7, 8'h01, 16'h0400}};

  dpt_top uut (.*);
  dpt_evt_src u_src (.clk_in(clk_in), .go_in(go), .slow_in(slow), .oe_n_in(timer_pin_oe_n_out),
                     .drv_in(timer_pin_out), .pin_out(timer_pin_in), .busy_out(busy));

  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  always @(posedge clk_in)
  begin
    if (match_interrupt_out[0] === 1'b1)
      n0 = n0 + 1;
    if (match_interrupt_out[1] === 1'b1)
      n1 = n1 + 1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask : wt

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_in);
      k++;
    end
    while (pready_out !== 1'b1 && k < 20);
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (k >= 20)
      chk(32'h0, 32'h1);
  endtask : apb

  task automatic wait_irq(input int ch);
    c = 0;
    do
    begin
      @(posedge clk_in);
      c++;
    end
    while (match_interrupt_out[ch] !== 1'b1 && c < 5000);
    if (c >= 5000)
      chk(32'h0, 32'h1);
  endtask : wait_irq

  task automatic hi_cnt(input int n);
    c = 0;
    repeat (n)
    begin
      @(posedge clk_in);
      c += (timer_pin_out[0] === 1'b1);
    end
  endtask : hi_cnt

  task automatic finish_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  initial
  begin
    wt(40000);
    chk(32'h0, 32'h1);
    finish_test();
  end

  initial
  begin
    rst_in = 1'b1;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 8'h00;
    pwdata_in = 32'h0;
    go = 1'b0;
    slow = 1'b0;
    fail_count = 0;
    checks = 0;
    n0 = 0;
    n1 = 0;
    wt(4);
    rst_in <= 1'b0;
    foreach (rows[i])
    begin
      apb(1'b1, `DPT_CS0_OFF, {29'h0, rows[i].cs});
      apb(1'b1, `DPT_CV0_OFF, {24'h0, rows[i].cv});
      apb(1'b1, `DPT_MC0_OFF, 32'h80);
      wait_irq(0);
      wait_irq(0);
      chk(c, {16'h0, rows[i].per});
      apb(1'b1, `DPT_MC0_OFF, 32'h0);
    end
    for (int s = 0; s < 2; s++)
    begin
      apb(1'b1, `DPT_CS0_OFF, s);
      apb(1'b1, `DPT_CV0_OFF, 32'h4);
      apb(1'b1, `DPT_MC0_OFF, 32'h80);
      n0 = 0;
      slow <= s[0];
      go <= 1'b1;
      wt(1);
      go <= 1'b0;
      wt(2);
      for (c = 0; busy === 1'b1 && c < 200; c++)
        wt(1);
      wt(3);
      chk(n0, 32'h1);
      apb(1'b0, `DPT_CC0_OFF, 32'h0);
      chk(r, 32'h3);
      apb(1'b1, `DPT_MC0_OFF, 32'h0);
    end
    apb(1'b1, `DPT_MC0_OFF, 32'h09);
    wt(3);
    chk(timer_pin_oe_n_out[0], 32'h0);
    chk(timer_pin_in[0], 32'h1);
    apb(1'b1, `DPT_CS0_OFF, 32'h2);
    apb(1'b1, `DPT_CV0_OFF, 32'h1);
    apb(1'b1, `DPT_MC0_OFF, 32'h83);
    wait_irq(0);
    wait_irq(0);
    chk(c, 32'h8);
    apb(1'b1, `DPT_MC0_OFF, 32'h03);
    apb(1'b0, `DPT_CC0_OFF, 32'h0);
    chk(r, 32'h0);
    apb(1'b1, `DPT_MC0_OFF, 32'h05);
    wt(3);
    chk(timer_pin_in[0], 32'h0);
    apb(1'b0, `DPT_MC0_OFF, 32'h0);
    chk(r, 32'h01);
    apb(1'b1, `DPT_MC0_OFF, 32'h0);
    wt(3);
    chk(timer_pin_oe_n_out[0], 32'h1);
    apb(1'b1, `DPT_CV0_OFF, 32'h40);
    apb(1'b1, `DPT_MC0_OFF, 32'hC1);
    hi_cnt(1000);
    chk(c, 32'h0);
    hi_cnt(1024);
    chk(c, 32'h100);
    apb(1'b1, `DPT_MC0_OFF, 32'hC3);
    wt(4);
    hi_cnt(1024);
    chk(c, 32'h300);
    // One compare write per period only
    apb(1'b1, `DPT_CV0_OFF, 32'h80);
    hi_cnt(1100);
    hi_cnt(1024);
    chk(c, 32'h200);
    apb(1'b1, `DPT_MC0_OFF, 32'h43);
    wt(4);
    chk(timer_pin_out[0], 32'h1);
    apb(1'b1, `DPT_MC0_OFF, 32'h0);
    apb(1'b1, `DPT_CV0_OFF, 32'h1);
    apb(1'b1, `DPT_CV1_OFF, 32'h1);
    apb(1'b1, `DPT_MC1_OFF, 32'h90);
    apb(1'b1, `DPT_MC0_OFF, 32'h80);
    n1 = 0;
    wait_irq(0);
    wait_irq(0);
    chk(c, 32'h408);
    chk(n1 != 0, 32'h1);
    // Upper half only trusted once two reads in a row agree
    c = 0;
    do
    begin
      r0 = r;
      apb(1'b0, `DPT_CC1_OFF, 32'h0);
      c++;
    end
    while ((c < 2 || r !== r0) && c < 8);
    chk(r, r0);
    chk(r < 32'h2, 32'h1);
    apb(1'b1, `DPT_MC0_OFF, 32'h0);
    n0 = 0;
    wt(1100);
    chk(n0, 32'h0);
    apb(1'b1, `DPT_MC1_OFF, 32'h0);
    apb(1'b1, `DPT_MC0_OFF, 32'h81);
    wt(50);
    rst_in <= 1'b1;
    wt(4);
    rst_in <= 1'b0;
    chk(timer_pin_oe_n_out, 32'h3);
    chk(timer_pin_out, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(r, 32'h0);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk(e, 32'h1);
    chk(r, 32'h0);
    finish_test();
  end
endmodule : tb_dual_8bit_pwm_timer
